// ---- logic/mlc_pkg.sv ----
// shared constants and types for the link control and status block
package mlc_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int LANES  = 20;
  localparam int CNT_W  = 4;
  localparam int DATA_W = 64;
  localparam int AW     = 12;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] REG_CTRL     = 12'h000;
  localparam logic [AW-1:0] REG_STATUS   = 12'h004;
  localparam logic [AW-1:0] REG_INT_STAT = 12'h008;
  localparam logic [AW-1:0] REG_INT_MASK = 12'h00C;
  // control fields
  localparam int CTRL_W     = 5;
  localparam int CTL_TX_EN  = 0;
  localparam int CTL_RFI    = 1;
  localparam int CTL_IDLE   = 2;
  localparam int CTL_RX_EN  = 3;
  localparam int CTL_RESYNC = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h08;
  // status fields
  localparam int ST_LF     = 0;
  localparam int ST_LOCKED = 1;
  localparam int ST_RX_RUN = 2;
  localparam int ST_LANE0  = 8;
  // interrupt fields
  localparam int INT_W      = 3;
  localparam int INT_LF     = 0;
  localparam int INT_UNLOCK = 1;
  localparam int INT_FERR   = 2;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;
  // ----------------------------------------------------------------
  // lane alignment counts (in headers)
  // ----------------------------------------------------------------
  localparam logic [6:0]       LOCK_GOOD = 7'h40;
  localparam logic [3:0]       WIN_LAST  = 4'hF;
  localparam logic [CNT_W-1:0] LOSE_ERR  = 4'h8;
  localparam logic [CNT_W-1:0] CNT_MAX   = 4'hF;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CODE_IDLE = 2'b00,
    CODE_DATA = 2'b01,
    CODE_RFI  = 2'b10,
    CODE_LF   = 2'b11
  } mlc_code_type;
  typedef enum logic [1:0] {
    TX_INIT = 2'b00,
    TX_IDLE = 2'b01,
    TX_PKT  = 2'b10
  } mlc_tx_state_type;
endpackage : mlc_pkg

// ---- logic/mlc_lane_mon.sv ----
// per-lane sync header monitor: lock tracking and framing error counts
`timescale 1ns/100ps
`default_nettype none
module mlc_lane_mon
  import mlc_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             run,
  input  wire logic             resync,
  input  wire logic             hdr_valid,
  input  wire logic             hdr_err,
  output logic                  locked_q,
  output logic [CNT_W-1:0]      cnt_q,
  output logic                  vld_q
);
  logic [6:0]       good_q, good_d;
  logic [3:0]       win_q, win_d;
  logic [CNT_W-1:0] acc_q, acc_d;
  logic             locked_d, vld_d;
  logic [CNT_W-1:0] cnt_d;

  // next state; decoding halts entirely while run is low
  always_comb begin
    logic [CNT_W-1:0] acc_n;
    acc_n    = acc_q;
    good_d   = good_q;
    win_d    = win_q;
    acc_d    = acc_q;
    locked_d = locked_q;
    cnt_d    = cnt_q;
    vld_d    = 1'b0;
    if (resync) begin
      good_d   = '0;
      win_d    = '0;
      acc_d    = '0;
      locked_d = 1'b0;
    end else if (run && hdr_valid) begin
      if (hdr_err) begin
        good_d = '0;
        if (acc_q != CNT_MAX) acc_n = acc_q + 4'h1; // saturate, never wrap
      end else if (!locked_q) begin
        if (good_q == LOCK_GOOD - 7'h01) locked_d = 1'b1;
        else good_d = good_q + 7'h01;
      end
      acc_d = acc_n;
      win_d = win_q + 4'h1;
      if (win_q == WIN_LAST) begin
        cnt_d = acc_n; // [R12] [R14]
        vld_d = 1'b1;  // [R13]
        acc_d = '0;
        if (locked_q && acc_n >= LOSE_ERR) locked_d = 1'b0;
      end
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      good_q   <= '0;
      win_q    <= '0;
      acc_q    <= '0;
      locked_q <= 1'b0;
      cnt_q    <= '0;
      vld_q    <= 1'b0;
    end else begin
      good_q   <= good_d;
      win_q    <= win_d;
      acc_q    <= acc_d;
      locked_q <= locked_d;
      cnt_q    <= cnt_d;
      vld_q    <= vld_d;
    end
  end
endmodule : mlc_lane_mon
`default_nettype wire

// ---- logic/mlc_pkt_gate.sv ----
// packet gate: lets a packet in progress finish after enable falls
`timescale 1ns/100ps
`default_nettype none
module mlc_pkt_gate (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic en,
  input  wire logic wvalid,
  input  wire logic weop,
  output logic      run,
  output logic      pass
);
  logic in_pkt_q, in_pkt_d;

  // open while enabled or while a packet is still open
  always_comb begin
    run      = en || in_pkt_q;
    pass     = wvalid && run;
    in_pkt_d = in_pkt_q;
    if (pass) in_pkt_d = !weop;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) in_pkt_q <= 1'b0;
    else          in_pkt_q <= in_pkt_d;
  end
endmodule : mlc_pkt_gate
`default_nettype wire

// ---- logic/mlc_top.sv ----
// link control and status block: tx code gating, rx gating, lane stats
`timescale 1ns/100ps
`default_nettype none
// Function
// R01: transmit permit low means only idle code words, no packet data.
// R02: permit falling mid-packet lets that packet finish, then no new packet.
// R03: user raises transmit permit only once the partner receiver is aligned.
// R04: remote fault request high sends remote fault code words only.
// R05: user holds remote fault request until local receive is aligned.
// R06: idle request high sends idle code words only.
// R07: user holds idle request while partner sends remote fault words.
// R08: local fault output is a level, high throughout transmit init state.
// R09: receive permit low: finish packet, stop decoding, no stats, bus idle.
// R10: forced resync high resets, resynchronises and realigns receive lanes.
// R11: user keeps forced resync low, pulsing it at least one cycle.
// R12: each lane outputs a 4-bit count of sync header errors.
// R13: a lane count is meaningful only while its valid strobe is high.
// R14: counts may update any cycle; user adds each valid count to a counter.
module mlc_top
  import mlc_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [AW-1:0]          paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  input  wire logic                   tx_word_valid,
  input  wire logic                   tx_word_eop,
  input  wire logic [DATA_W-1:0]      tx_word_data,
  output logic                        tx_word_ready,
  output mlc_code_type                tx_code,
  output logic [DATA_W-1:0]           tx_code_data,
  output logic                        tx_code_eop,
  output logic                        stat_tx_local_fault,
  input  wire logic [LANES-1:0]       rx_hdr_valid,
  input  wire logic [LANES-1:0]       rx_hdr_err,
  input  wire logic                   rx_word_valid,
  input  wire logic                   rx_word_eop,
  input  wire logic [DATA_W-1:0]      rx_word_data,
  output logic                        rx_out_valid,
  output logic                        rx_out_eop,
  output logic [DATA_W-1:0]           rx_out_data,
  output logic [LANES*CNT_W-1:0]      stat_rx_framing_err,
  output logic [LANES-1:0]            stat_rx_framing_err_valid
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0]  ctrl_q, ctrl_d;
  logic [INT_W-1:0]   int_q, int_d, mask_q, mask_d, ev;
  logic [31:0]        prdata_q, prdata_d;
  logic               pready_q, pready_d, pslverr_q, pslverr_d;
  logic               irq_q, irq_d;
  logic               wr_done, rd_done, hit;
  mlc_tx_state_type   tx_state_q, tx_state_d;
  mlc_code_type       code_q, code_d;
  logic [DATA_W-1:0]  tx_data_q, tx_data_d;
  logic               tx_eop_q, tx_eop_d, ready_q, ready_d, lf_q, lf_d;
  logic               tx_take;
  logic               rx_run, rx_pass;
  logic               rx_vld_q, rx_vld_d, rx_eop_q, rx_eop_d;
  logic [DATA_W-1:0]  rx_data_q, rx_data_d;
  logic [LANES-1:0]   lane_lock, lane_vld, lane_nz;
  logic               all_locked, locked_q;

  // ----------------------------------------------------------------
  // apb slave: one wait state, then pready for one cycle
  // ----------------------------------------------------------------
  assign wr_done = psel && penable && pready_q && pwrite;
  assign rd_done = psel && penable && pready_q && !pwrite;
  assign hit = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
               (paddr == REG_INT_STAT) || (paddr == REG_INT_MASK);

  // control, mask and sticky interrupt next values
  always_comb begin
    ctrl_d = ctrl_q;
    ctrl_d[CTL_RESYNC] = 1'b0; // resync is a one-cycle pulse
    mask_d = mask_q;
    if (wr_done && paddr == REG_CTRL) ctrl_d = pwdata[CTRL_W-1:0];
    if (wr_done && paddr == REG_INT_MASK) mask_d = pwdata[INT_W-1:0];
    // a set in the clearing cycle wins, so no event is lost
    int_d = int_q;
    if (rd_done && paddr == REG_INT_STAT) int_d = '0;
    int_d = int_d | ev;
    irq_d = |(int_d & mask_d);
  end

  // read data mux and answer timing
  always_comb begin
    pready_d  = psel && penable && !pready_q;
    pslverr_d = pready_d && !hit;
    prdata_d  = '0;
    if (pready_d && !pwrite) begin
      unique case (paddr)
        REG_CTRL:     prdata_d[CTRL_W-1:0] = ctrl_q;
        REG_STATUS: begin
          prdata_d[ST_LF]     = lf_q;
          prdata_d[ST_LOCKED] = locked_q;
          prdata_d[ST_RX_RUN] = rx_run;
          prdata_d[ST_LANE0 +: LANES] = lane_lock;
        end
        REG_INT_STAT: prdata_d[INT_W-1:0] = int_d; // includes this cycle's set
        REG_INT_MASK: prdata_d[INT_W-1:0] = mask_q;
        default:      prdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= CTRL_RST;
      mask_q    <= INT_MASK_RST;
      int_q     <= '0;
      irq_q     <= 1'b0;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      mask_q    <= mask_d;
      int_q     <= int_d;
      irq_q     <= irq_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // transmit state and code word selection
  // ----------------------------------------------------------------
  assign tx_take = tx_word_valid && ready_q;

  // forced code words take priority over everything, rfi first
  always_comb begin
    tx_state_d = tx_state_q;
    code_d     = CODE_IDLE; // [R01]
    tx_data_d  = '0;
    tx_eop_d   = 1'b0;
    unique case (tx_state_q)
      TX_INIT: if (locked_q) tx_state_d = TX_IDLE;
      TX_IDLE: begin
        if (!locked_q) tx_state_d = TX_INIT;
        else if (tx_take && !tx_word_eop) tx_state_d = TX_PKT;
      end
      TX_PKT:  if (tx_take && tx_word_eop) tx_state_d = TX_IDLE; // [R02]
      default: tx_state_d = TX_INIT;
    endcase
    if (ctrl_q[CTL_RFI]) code_d = CODE_RFI;             // [R04]
    else if (ctrl_q[CTL_IDLE]) code_d = CODE_IDLE;      // [R06]
    else if (tx_state_q == TX_INIT) code_d = CODE_LF;
    else if (tx_take) begin
      code_d    = CODE_DATA;
      tx_data_d = tx_word_data;
      tx_eop_d  = tx_word_eop;
    end
    lf_d = (tx_state_d == TX_INIT); // [R08]
    // ready uses next-cycle values so a permit drop is honoured at once
    ready_d = !ctrl_d[CTL_RFI] && !ctrl_d[CTL_IDLE] &&
              ((tx_state_d == TX_PKT) ||
               (tx_state_d == TX_IDLE && ctrl_d[CTL_TX_EN])); // [R01] [R02]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= TX_INIT;
      code_q     <= CODE_LF;
      tx_data_q  <= '0;
      tx_eop_q   <= 1'b0;
      ready_q    <= 1'b0;
      lf_q       <= 1'b1;
    end else begin
      tx_state_q <= tx_state_d;
      code_q     <= code_d;
      tx_data_q  <= tx_data_d;
      tx_eop_q   <= tx_eop_d;
      ready_q    <= ready_d;
      lf_q       <= lf_d;
    end
  end

  // ----------------------------------------------------------------
  // receive gating and lane monitors
  // ----------------------------------------------------------------
  mlc_pkt_gate u_rx_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (ctrl_q[CTL_RX_EN]),
    .wvalid  (rx_word_valid),
    .weop    (rx_word_eop),
    .run     (rx_run),
    .pass    (rx_pass)
  );

  // one monitor per lane; decoding stops with rx_run low
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    mlc_lane_mon u_lane (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (rx_run),            // [R09]
      .resync    (ctrl_q[CTL_RESYNC]), // [R10]
      .hdr_valid (rx_hdr_valid[i]),
      .hdr_err   (rx_hdr_err[i]),
      .locked_q  (lane_lock[i]),
      .cnt_q     (stat_rx_framing_err[i*CNT_W +: CNT_W]),
      .vld_q     (lane_vld[i])
    );
    assign lane_nz[i] = lane_vld[i] && (stat_rx_framing_err[i*CNT_W +: CNT_W] != '0);
  end

  assign all_locked = &lane_lock;

  // user data passes only once every lane is aligned
  always_comb begin
    rx_vld_d  = rx_pass && locked_q; // [R09]
    rx_eop_d  = rx_vld_d && rx_word_eop;
    rx_data_d = rx_vld_d ? rx_word_data : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_vld_q  <= 1'b0;
      rx_eop_q  <= 1'b0;
      rx_data_q <= '0;
      locked_q  <= 1'b0;
    end else begin
      rx_vld_q  <= rx_vld_d;
      rx_eop_q  <= rx_eop_d;
      rx_data_q <= rx_data_d;
      locked_q  <= all_locked;
    end
  end

  // interrupt events: init entry, alignment loss, nonzero error count
  always_comb begin
    ev = '0;
    ev[INT_LF]     = lf_d && !lf_q;
    ev[INT_UNLOCK] = locked_q && !all_locked;
    ev[INT_FERR]   = |lane_nz;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata                    = prdata_q;
  assign pready                    = pready_q;
  assign pslverr                   = pslverr_q;
  assign irq                       = irq_q;
  assign tx_word_ready             = ready_q;
  assign tx_code                   = code_q;
  assign tx_code_data              = tx_data_q;
  assign tx_code_eop               = tx_eop_q;
  assign stat_tx_local_fault       = lf_q; // [R08]
  assign rx_out_valid              = rx_vld_q;
  assign rx_out_eop                = rx_eop_q;
  assign rx_out_data               = rx_data_q;
  assign stat_rx_framing_err_valid = lane_vld; // [R13]

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_data_needs_permit: assert property ( // [R01]
    (code_q == CODE_DATA) |-> $past(ctrl_q[CTL_TX_EN] || tx_state_q == TX_PKT))
    else $error("data sent without transmit permit");

  a_pkt_runs_out: assert property ( // [R02]
    (tx_state_q == TX_PKT && !ctrl_q[CTL_TX_EN] && !(tx_take && tx_word_eop))
    |=> tx_state_q == TX_PKT)
    else $error("packet cut short by permit drop");

  a_no_start_off: assert property ( // [R01]
    (tx_state_q == TX_IDLE && !ctrl_q[CTL_TX_EN]) |-> !ready_q)
    else $error("ready offered while permit low");

  a_rfi_only: assert property ( // [R04]
    ctrl_q[CTL_RFI] |=> code_q == CODE_RFI)
    else $error("remote fault request ignored");

  a_idle_only: assert property ( // [R06]
    (ctrl_q[CTL_IDLE] && !ctrl_q[CTL_RFI]) |=> code_q == CODE_IDLE)
    else $error("idle request ignored");

  a_lf_level: assert property ( // [R08]
    (tx_state_q == TX_INIT) == lf_q)
    else $error("local fault level out of step with init state");

  a_rx_quiet: assert property ( // [R09]
    !rx_run |=> (!rx_vld_q && lane_vld == '0))
    else $error("receive active while stopped");

  a_resync_unlock: assert property ( // [R10]
    ctrl_q[CTL_RESYNC] |=> (lane_lock == '0) ##1 !locked_q)
    else $error("resync left lanes locked");

  a_valid_pulse: assert property ( // [R13]
    lane_vld[0] |=> !lane_vld[0] [*8])
    else $error("count valid strobes too close");

  a_ferr_sticky: assert property (
    lane_nz[3] |=> int_q[INT_FERR])
    else $error("framing error event not recorded");

  a_ready_blocked: assert property ( // [R04] [R06]
    (ctrl_q[CTL_RFI] || ctrl_q[CTL_IDLE]) |-> !ready_q)
    else $error("word taken while a code is forced");

  a_lf_no_data: assert property ( // [R08]
    lf_q |=> code_q != CODE_DATA)
    else $error("data sent from init state");

  a_strobe_needs_run: assert property ( // [R09]
    (lane_vld != '0) |-> $past(rx_run))
    else $error("statistics reported while stopped");

  a_eop_in_word: assert property ( // [R09]
    rx_eop_q |-> rx_vld_q)
    else $error("receive end flag without a word");

  a_irq_level: assert property (
    irq_q == |(int_q & mask_q))
    else $error("interrupt out of step with status");

  a_resync_pulse: assert property ( // [R10]
    ctrl_q[CTL_RESYNC] |=> !ctrl_q[CTL_RESYNC])
    else $error("resync held beyond one cycle");

  // covers: the main scenarios the bench walks through
  c_packet: cover property (tx_state_q == TX_PKT ##[1:20] tx_eop_q);
  c_ferr: cover property (lane_nz[3]);
  c_resync: cover property (ctrl_q[CTL_RESYNC] ##[1:200] locked_q);
  c_rfi: cover property (code_q == CODE_RFI);
  c_rx_word: cover property (rx_vld_q && rx_eop_q);
endmodule : mlc_top
`default_nettype wire

// ---- testbench/mlc_lane_src.sv ----
// link partner model: sync headers on all receive lanes
`timescale 1ns/100ps
`default_nettype none
module mlc_lane_src
  import mlc_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [LANES-1:0] err_lanes,
  output logic      [LANES-1:0] hdr_valid,
  output logic      [LANES-1:0] hdr_err
);
  logic [2:0] phase_q;
  // ----------------------------------------------------------------
  // header stream
  // ----------------------------------------------------------------
  // a header every cycle; marked lanes go bad once in eight, so any
  // sixteen-header window holds exactly two errors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q   <= 3'h0;
      hdr_valid <= '0;
      hdr_err   <= '1; // meaningless while no header is flagged
    end else begin
      phase_q   <= phase_q + 3'h1;
      hdr_valid <= '1;
      hdr_err   <= (phase_q == 3'h3) ? err_lanes : '0;
    end
  end
endmodule : mlc_lane_src
`default_nettype wire

// ---- testbench/tb_mlc_top.sv ----
// self-checking bench for the link control and status block
`timescale 1ns/100ps
`default_nettype none
module tb_mlc_top;
  import mlc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                     pclk          = 1'b0;
  logic                     presetn       = 1'b0;
  logic                     psel          = 1'b0;
  logic                     penable       = 1'b0;
  logic                     pwrite        = 1'b0;
  logic [AW-1:0]            paddr         = '0;
  logic [31:0]              pwdata        = '0;
  logic                     tx_word_valid = 1'b0;
  logic                     tx_word_eop   = 1'b0;
  logic [DATA_W-1:0]        tx_word_data  = '0;
  logic                     rx_word_valid = 1'b0;
  logic                     rx_word_eop   = 1'b0;
  logic [DATA_W-1:0]        rx_word_data  = '0;
  logic [LANES-1:0]         lane_err      = '0;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     irq;
  logic                     tx_word_ready;
  mlc_code_type             tx_code;
  logic [DATA_W-1:0]        tx_code_data;
  logic                     tx_code_eop;
  logic                     stat_tx_local_fault;
  logic [LANES-1:0]         rx_hdr_valid;
  logic [LANES-1:0]         rx_hdr_err;
  logic                     rx_out_valid;
  logic                     rx_out_eop;
  logic [DATA_W-1:0]        rx_out_data;
  logic [LANES*CNT_W-1:0]   stat_rx_framing_err;
  logic [LANES-1:0]         stat_rx_framing_err_valid;
  logic [31:0]              rd;
  logic                     er;
  int                       n_fail        = 0;
  int                       check_count   = 0;
  int                       cyc           = 0;

  always #12.5 pclk = ~pclk;

  mlc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .tx_word_valid(tx_word_valid), .tx_word_eop(tx_word_eop), .tx_word_data(tx_word_data),
    .tx_word_ready(tx_word_ready), .tx_code(tx_code), .tx_code_data(tx_code_data),
    .tx_code_eop(tx_code_eop), .stat_tx_local_fault(stat_tx_local_fault),
    .rx_hdr_valid(rx_hdr_valid), .rx_hdr_err(rx_hdr_err), .rx_word_valid(rx_word_valid),
    .rx_word_eop(rx_word_eop), .rx_word_data(rx_word_data), .rx_out_valid(rx_out_valid),
    .rx_out_eop(rx_out_eop), .rx_out_data(rx_out_data), .stat_rx_framing_err(stat_rx_framing_err),
    .stat_rx_framing_err_valid(stat_rx_framing_err_valid));

  mlc_lane_src partner (.pclk(pclk), .presetn(presetn), .err_lanes(lane_err),
    .hdr_valid(rx_hdr_valid), .hdr_err(rx_hdr_err));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // apb transfer, entered at a rising edge; waits for pready with no fixed count
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is read at the edge, before that edge updates it
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdc(input logic [AW-1:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0000_0000);
    chk("read data", rd, exp);
    chk("slave error", er, exp_err);
  endtask : rdc

  // bounded wait for the local fault level
  task automatic wait_lf(input logic v);
    for (int i = 0; i < 300; i++) begin
      @(posedge pclk);
      #1;
      if (stat_tx_local_fault === v) break;
    end
    chk("local fault", stat_tx_local_fault, v);
    @(posedge pclk);
  endtask : wait_lf

  // one word out; the code word follows the taking edge
  task automatic send(input logic [63:0] d, input logic eop);
    tx_word_valid <= 1'b1;
    tx_word_data  <= d;
    tx_word_eop   <= eop;
    for (int i = 0; i < 50; i++) begin
      #1;
      if (tx_word_ready === 1'b1) break;
      @(posedge pclk);
    end
    @(posedge pclk);
    tx_word_valid <= 1'b0;
    #1;
    chk("tx code", tx_code, CODE_DATA);
    chk("tx data", tx_code_data, d);
    chk("tx eop", tx_code_eop, eop);
    @(posedge pclk);
  endtask : send

  // word offered but held back; only the given code goes out
  task automatic held(input mlc_code_type exp);
    tx_word_valid <= 1'b1;
    repeat (3) @(posedge pclk);
    repeat (4) begin
      @(posedge pclk);
      #1;
      chk("tx ready", tx_word_ready, 1'b0);
      chk("tx code", tx_code, exp);
    end
    @(posedge pclk);
    tx_word_valid <= 1'b0;
  endtask : held

  // bounded wait for the lane 3 strobe
  task automatic wait_vld3;
    for (int i = 0; i < 60; i++) begin
      @(posedge pclk);
      #1;
      if (stat_rx_framing_err_valid[3] === 1'b1) break;
    end
  endtask : wait_vld3

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    #1;
    chk("tx code", tx_code, CODE_LF);
    chk("local fault", stat_tx_local_fault, 1'b1);
    @(posedge pclk);
    rdc(REG_CTRL, 32'h0000_0008, 1'b0);
    rdc(REG_INT_MASK, 32'h0000_0000, 1'b0);
    rdc(12'h010, 32'h0000_0000, 1'b1); // unmapped place refused
  endtask : t_reset

  task automatic t_packet;
    wait_lf(1'b0);
    rdc(REG_STATUS, 32'h0FFF_FF06, 1'b0);
    held(CODE_IDLE);
    apb(1'b1, REG_CTRL, 32'h0000_0009);
    send(64'h0123_4567_89AB_CDEF, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0000_0008); // permit drops mid packet
    send(64'hFEDC_BA98_7654_3210, 1'b0);
    send(64'h0F0F_0F0F_0F0F_0F0F, 1'b1);
    held(CODE_IDLE);
  endtask : t_packet

  task automatic t_force;
    apb(1'b1, REG_CTRL, 32'h0000_000B);
    held(CODE_RFI);
    apb(1'b1, REG_CTRL, 32'h0000_000D);
    held(CODE_IDLE);
    apb(1'b1, REG_CTRL, 32'h0000_0008);
  endtask : t_force

  // first strobe may cover a partial window, so judge the second
  task automatic t_frame;
    lane_err <= 20'h0_0008;
    wait_vld3;
    @(posedge pclk);
    wait_vld3;
    chk("lane 3 count", stat_rx_framing_err[15:12], 4'h2);
    chk("lane 0 count", stat_rx_framing_err[3:0], 4'h0);
    chk("irq masked", irq, 1'b0);
    @(posedge pclk);
    #1;
    chk("strobe width", stat_rx_framing_err_valid[3], 1'b0);
    @(posedge pclk);
    apb(1'b1, REG_INT_MASK, 32'h0000_0004);
    @(posedge pclk);
    #1;
    chk("irq", irq, 1'b1);
    @(posedge pclk);
    lane_err <= '0;
    repeat (40) @(posedge pclk);
    apb(1'b0, REG_INT_STAT, 32'h0000_0000);
    chk("framing event", rd[INT_FERR], 1'b1);
    apb(1'b0, REG_INT_STAT, 32'h0000_0000);
    chk("event cleared", rd[INT_FERR], 1'b0);
    #1;
    chk("irq cleared", irq, 1'b0);
    @(posedge pclk);
  endtask : t_frame

  task automatic t_rx;
    rx_word_valid <= 1'b1;
    rx_word_eop   <= 1'b1;
    rx_word_data  <= 64'h5A5A_0000_1234_A5A5;
    @(posedge pclk);
    rx_word_valid <= 1'b0;
    #1;
    chk("rx valid", rx_out_valid, 1'b1);
    chk("rx data", rx_out_data, 64'h5A5A_0000_1234_A5A5);
    chk("rx eop", rx_out_eop, 1'b1);
    @(posedge pclk);
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    lane_err      <= 20'h0_0008;
    rx_word_valid <= 1'b1;
    repeat (40) begin
      @(posedge pclk);
      #1;
      chk("rx valid off", rx_out_valid, 1'b0);
      chk("stats off", stat_rx_framing_err_valid, 20'h0_0000);
    end
    @(posedge pclk);
    rx_word_valid <= 1'b0;
    lane_err      <= '0;
    apb(1'b1, REG_CTRL, 32'h0000_0008);
  endtask : t_rx

  task automatic t_resync;
    apb(1'b1, REG_CTRL, 32'h0000_0018);
    wait_lf(1'b1);
    #1;
    chk("tx code", tx_code, CODE_LF);
    @(posedge pclk);
    rdc(REG_CTRL, 32'h0000_0008, 1'b0);
    wait_lf(1'b0);
    rdc(REG_INT_STAT, 32'h0000_0003, 1'b0);
  endtask : t_resync

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic results;
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results;
    end
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_packet;
    t_force;
    t_frame;
    t_rx;
    t_resync;
    results;
  end
endmodule : tb_mlc_top
`default_nettype wire
